// ### src/dgp_pkg.sv
// constants, register map and types for the dual gpio port block
// Behaviour
// - port a six pins, direction one means input
// - port a read gives pins, write sets latch
// - port writes without byte lane 0 write the pins back to the latch
// - a4 timer clock input, open-drain output only
// - a5 also slave select and analog input
// - three-bit field selects analog or digital pins
// - after reset analog pins read as zero
// - port b eight pins, same direction rule
// - option bit 7 low enables port b pull-ups
// - pull-up forced off on output pins
// - pull-ups off after reset, option all ones
// - change detect on b7..b4 inputs only
// - mismatch against last port b access, read or write, sets change flag
// - mismatch keeps flag set until port access
// - port change can wake from sleep
// - b0 external interrupt, edge from option bit 6
// - b6 and b7 carry programming clock and data
// - flags set regardless of enable bits
`default_nettype none
package dgp_pkg;
    localparam int unsigned PA_W = 6;
    localparam int unsigned PB_W = 8;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned ANA_SEL_W = 3;
    localparam int unsigned CHG_LO = 4;
    localparam int unsigned CHG_W = 4;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PORT_A = 8'h05;
    localparam logic [7:0] IDX_PORT_B = 8'h06;
    localparam logic [7:0] IDX_INT_CTRL = 8'h0b;
    localparam logic [7:0] IDX_OPTION = 8'h81;
    localparam logic [7:0] IDX_DIR_A = 8'h85;
    localparam logic [7:0] IDX_DIR_B = 8'h86;
    localparam logic [7:0] IDX_ANALOG = 8'h9f;

    localparam logic [7:0] OPTION_RST = 8'hff;
    localparam logic [PA_W-1:0] DIR_A_RST = 6'h3f;
    localparam logic [PB_W-1:0] DIR_B_RST = 8'hff;
    localparam logic [ANA_SEL_W-1:0] ANALOG_RST = 3'h0;
    localparam logic [PA_W-1:0] LATCH_A_RST = 6'h00;
    localparam logic [PB_W-1:0] LATCH_B_RST = 8'h00;

    localparam int unsigned OPT_PULLUP_N_BIT = 7;
    localparam int unsigned OPT_EDGE_BIT = 6;
    localparam int unsigned INT_CHG_FLAG_BIT = 0;
    localparam int unsigned INT_EXT_FLAG_BIT = 1;
    localparam int unsigned INT_CHG_EN_BIT = 3;
    localparam int unsigned INT_EXT_EN_BIT = 4;
    localparam int unsigned PA_OD_BIT = 4;
    localparam int unsigned PA_SS_BIT = 5;
    localparam int unsigned PB_EXT_BIT = 0;
    localparam int unsigned PB_PCLK_BIT = 6;
    localparam int unsigned PB_PDATA_BIT = 7;

    typedef enum logic [1:0] {
        DGP_IDLE = 2'b01,
        DGP_ACK = 2'b10
    } dgp_apb_e;

    // analog pin mask per select code; bit 4 never analog
    function automatic logic [PA_W-1:0] dgp_ana_mask(input logic [ANA_SEL_W-1:0] sel);
        logic [PA_W-1:0] m;
        m = 6'h00;
        case (sel)
            3'h0: m = 6'h2f;
            3'h1: m = 6'h0f;
            3'h2: m = 6'h07;
            3'h3: m = 6'h03;
            3'h4: m = 6'h01;
            default: m = 6'h00;
        endcase
        return m;
    endfunction
endpackage
`default_nettype wire

// ### src/dgp_sync.sv
// two-flop synchroniser for the port pin inputs
`timescale 1ns/1ps
`default_nettype none
module dgp_sync #(
    parameter int unsigned W = 14
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_reg;

    initial begin
        if (W < 1) $error("dgp_sync width must be at least 1");
    end

    // meta_reg feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            q_out <= '0;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule // dgp_sync
`default_nettype wire

// ### src/dgp_change_det.sv
// port b upper-nibble change detector with last-access snapshot
`timescale 1ns/1ps
`default_nettype none
module dgp_change_det #(
    parameter int unsigned W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] pins,
    input wire logic [W-1:0] in_mask,
    input wire logic load,
    output logic mismatch
);
    logic [W-1:0] snap_reg;

    initial begin
        if (W < 1) $error("dgp_change_det width must be at least 1");
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snap_reg <= '0;
        end else if (load) begin
            snap_reg <= pins;
        end
    end

    // outputs are excluded by the mask, a port access restarts compare
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mismatch <= 1'b0;
        end else begin
            mismatch <= !load && (|((pins ^ snap_reg) & in_mask));
        end
    end

    a_load_ends_miss: assert property (@(posedge pclk) disable iff (!presetn)
        load |=> !mismatch)
        else $error("mismatch survived a port b access");
    a_output_excluded: assert property (@(posedge pclk) disable iff (!presetn)
        (in_mask == '0) |=> !mismatch)
        else $error("mismatch raised with no input pins");
endmodule // dgp_change_det
`default_nettype wire

// ### src/dgp_top.sv
// dual gpio port with change detect, apb register slave
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dgp_top #(
    parameter bit ANALOG_PRESENT = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dgp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [dgp_pkg::PA_W-1:0] pa_in,
    output logic [dgp_pkg::PA_W-1:0] pa_out,
    output logic [dgp_pkg::PA_W-1:0] pa_oe,
    output logic [dgp_pkg::PA_W-1:0] analog_en,
    input wire logic [dgp_pkg::PB_W-1:0] pb_in,
    output logic [dgp_pkg::PB_W-1:0] pb_out,
    output logic [dgp_pkg::PB_W-1:0] pb_oe,
    output logic [dgp_pkg::PB_W-1:0] pb_pullup_en,
    output logic timer_ext_clock_in,
    output logic ssp_slave_select_n,
    output logic prog_clock,
    output logic prog_data,
    output logic port_change_flag,
    output logic ext_irq_flag,
    output logic wake_req
);
    localparam int unsigned PA_W = dgp_pkg::PA_W;
    localparam int unsigned PB_W = dgp_pkg::PB_W;
    localparam int unsigned SW = PA_W + PB_W;

    initial begin
        if (PA_W > 8 || PB_W > 8) $error("port width exceeds byte lane");
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [SW-1:0] pins_sync;
    logic [PA_W-1:0] pa_sync;
    logic [PB_W-1:0] pb_sync;

    dgp_sync #(.W(SW)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d_in({pb_in, pa_in}),
        .q_out(pins_sync)
    );

    assign pa_sync = pins_sync[PA_W-1:0];
    assign pb_sync = pins_sync[SW-1:PA_W];

    // ************************************************************
    // apb slave
    // ************************************************************
    dgp_pkg::dgp_apb_e state_reg;
    logic [7:0] idx;
    logic hit_a;
    logic hit_b;
    logic hit_int;
    logic hit_opt;
    logic hit_dir_a;
    logic hit_dir_b;
    logic hit_ana;
    logic mapped;
    logic commit;
    logic wr_en;
    logic rd_en;
    logic [7:0] rdata;

    assign idx = paddr[9:2];
    assign hit_a = (idx == dgp_pkg::IDX_PORT_A);
    assign hit_b = (idx == dgp_pkg::IDX_PORT_B);
    assign hit_int = (idx == dgp_pkg::IDX_INT_CTRL);
    assign hit_opt = (idx == dgp_pkg::IDX_OPTION);
    assign hit_dir_a = (idx == dgp_pkg::IDX_DIR_A);
    assign hit_dir_b = (idx == dgp_pkg::IDX_DIR_B);
    assign hit_ana = (idx == dgp_pkg::IDX_ANALOG);
    assign mapped = hit_a | hit_b | hit_int | hit_opt | hit_dir_a | hit_dir_b | hit_ana;
    // writes and read side effects happen only at the completing edge
    assign commit = (state_reg == dgp_pkg::DGP_ACK) && psel && penable;
    assign wr_en = commit && pwrite && mapped && pstrb[0];
    assign rd_en = commit && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= dgp_pkg::DGP_IDLE;
        end else begin
            case (state_reg)
                dgp_pkg::DGP_IDLE: begin
                    if (psel && penable) begin
                        state_reg <= dgp_pkg::DGP_ACK;
                    end
                end
                dgp_pkg::DGP_ACK: begin
                    state_reg <= dgp_pkg::DGP_IDLE;
                end
                default: begin
                    state_reg <= dgp_pkg::DGP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= (state_reg == dgp_pkg::DGP_IDLE) && psel && penable;
            pslverr <= (state_reg == dgp_pkg::DGP_IDLE) && psel && penable && !mapped;
            if ((state_reg == dgp_pkg::DGP_IDLE) && psel && penable && !pwrite) begin
                prdata <= {24'h000000, rdata};
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    logic [PA_W-1:0] latch_a_reg;
    logic [PA_W-1:0] dir_a_reg;
    logic [PB_W-1:0] latch_b_reg;
    logic [PB_W-1:0] dir_b_reg;
    logic [7:0] opt_reg;
    logic [dgp_pkg::ANA_SEL_W-1:0] ana_sel_reg;
    logic chg_flag_reg;
    logic ext_flag_reg;
    logic chg_en_reg;
    logic ext_en_reg;
    logic [PA_W-1:0] ana_mask;
    logic [PA_W-1:0] pa_read;

    assign ana_mask = ANALOG_PRESENT ? dgp_pkg::dgp_ana_mask(ana_sel_reg) : '0;
    // analog pins have their digital buffer off and read as zero
    assign pa_read = pa_sync & ~ana_mask;

    always_comb begin
        rdata = 8'h00;
        case (1'b1)
            hit_a: rdata = {2'b00, pa_read};
            hit_b: rdata = pb_sync;
            hit_int: rdata = {3'b000, ext_en_reg, chg_en_reg, 1'b0, ext_flag_reg, chg_flag_reg};
            hit_opt: rdata = opt_reg;
            hit_dir_a: rdata = {2'b00, dir_a_reg};
            hit_dir_b: rdata = dir_b_reg;
            hit_ana: rdata = {5'b00000, ana_sel_reg};
            default: rdata = 8'h00;
        endcase
    end

    // a write stores the byte lane; without lane 0 the pins are written back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_a_reg <= dgp_pkg::LATCH_A_RST;
        end else if (commit && pwrite && hit_a) begin
            latch_a_reg <= pstrb[0] ? pwdata[PA_W-1:0] : pa_read;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_b_reg <= dgp_pkg::LATCH_B_RST;
        end else if (commit && pwrite && hit_b) begin
            latch_b_reg <= pstrb[0] ? pwdata[PB_W-1:0] : pb_sync;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_a_reg <= dgp_pkg::DIR_A_RST;
            dir_b_reg <= dgp_pkg::DIR_B_RST;
            opt_reg <= dgp_pkg::OPTION_RST;
            ana_sel_reg <= dgp_pkg::ANALOG_RST;
        end else if (wr_en) begin
            if (hit_dir_a) dir_a_reg <= pwdata[PA_W-1:0];
            if (hit_dir_b) dir_b_reg <= pwdata[PB_W-1:0];
            if (hit_opt) opt_reg <= pwdata[7:0];
            if (hit_ana) ana_sel_reg <= pwdata[dgp_pkg::ANA_SEL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_en_reg <= 1'b0;
            ext_en_reg <= 1'b0;
        end else if (wr_en && hit_int) begin
            chg_en_reg <= pwdata[dgp_pkg::INT_CHG_EN_BIT];
            ext_en_reg <= pwdata[dgp_pkg::INT_EXT_EN_BIT];
        end
    end

    // ************************************************************
    // port change detection
    // ************************************************************
    logic mismatch;
    logic snap_load;

    // polling port b also reloads the snapshot and can hide a change
    assign snap_load = commit && hit_b;

    dgp_change_det #(.W(dgp_pkg::CHG_W)) u_chg (
        .pclk(pclk),
        .presetn(presetn),
        .pins(pb_sync[dgp_pkg::CHG_LO +: dgp_pkg::CHG_W]),
        .in_mask(dir_b_reg[dgp_pkg::CHG_LO +: dgp_pkg::CHG_W]),
        .load(snap_load),
        .mismatch(mismatch)
    );

    // set wins over a software clear; enables do not gate the set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_flag_reg <= 1'b0;
        end else if (mismatch) begin
            chg_flag_reg <= 1'b1;
        end else if (wr_en && hit_int) begin
            chg_flag_reg <= pwdata[dgp_pkg::INT_CHG_FLAG_BIT];
        end
    end

    // ************************************************************
    // external interrupt pin
    // ************************************************************
    logic ext_prev_reg;
    logic ext_edge;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= pb_sync[dgp_pkg::PB_EXT_BIT];
        end
    end

    // edge select one picks rising, zero picks falling
    assign ext_edge = opt_reg[dgp_pkg::OPT_EDGE_BIT]
        ? (pb_sync[dgp_pkg::PB_EXT_BIT] && !ext_prev_reg)
        : (!pb_sync[dgp_pkg::PB_EXT_BIT] && ext_prev_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_flag_reg <= 1'b0;
        end else if (ext_edge) begin
            ext_flag_reg <= 1'b1;
        end else if (wr_en && hit_int) begin
            ext_flag_reg <= pwdata[dgp_pkg::INT_EXT_FLAG_BIT];
        end
    end

    // ************************************************************
    // pin drivers and alternate functions
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < PA_W; gi++) begin : g_pa
            if (gi == dgp_pkg::PA_OD_BIT) begin : g_od
                // open drain: only ever pulls low, never drives high
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        pa_out[gi] <= 1'b0;
                        pa_oe[gi] <= 1'b0;
                    end else begin
                        pa_out[gi] <= 1'b0;
                        pa_oe[gi] <= !dir_a_reg[gi] && !latch_a_reg[gi];
                    end
                end
            end else begin : g_pp
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        pa_out[gi] <= 1'b0;
                        pa_oe[gi] <= 1'b0;
                    end else begin
                        pa_out[gi] <= latch_a_reg[gi];
                        // direction stays active in analog mode; software keeps it set
                        pa_oe[gi] <= !dir_a_reg[gi];
                    end
                end
            end
        end
        for (gi = 0; gi < PB_W; gi++) begin : g_pb
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pb_out[gi] <= 1'b0;
                    pb_oe[gi] <= 1'b0;
                    pb_pullup_en[gi] <= 1'b0;
                end else begin
                    pb_out[gi] <= latch_b_reg[gi];
                    pb_oe[gi] <= !dir_b_reg[gi];
                    pb_pullup_en[gi] <= !opt_reg[dgp_pkg::OPT_PULLUP_N_BIT] && dir_b_reg[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_en <= '0;
            timer_ext_clock_in <= 1'b0;
            ssp_slave_select_n <= 1'b1;
            prog_clock <= 1'b0;
            prog_data <= 1'b0;
            port_change_flag <= 1'b0;
            ext_irq_flag <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            analog_en <= ana_mask;
            timer_ext_clock_in <= pa_sync[dgp_pkg::PA_OD_BIT];
            // slave select reads high when the pin is analog
            ssp_slave_select_n <= pa_sync[dgp_pkg::PA_SS_BIT] || ana_mask[dgp_pkg::PA_SS_BIT];
            prog_clock <= pb_sync[dgp_pkg::PB_PCLK_BIT];
            prog_data <= pb_sync[dgp_pkg::PB_PDATA_BIT];
            port_change_flag <= chg_flag_reg;
            ext_irq_flag <= ext_flag_reg;
            wake_req <= (chg_flag_reg && chg_en_reg) || (ext_flag_reg && ext_en_reg);
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rd_a;
        (state_reg == dgp_pkg::DGP_IDLE) && psel && penable && !pwrite && hit_a;
    endsequence

    sequence s_wr_a_rmw;
        commit && pwrite && hit_a && !pstrb[0];
    endsequence

    a_read_pins_a: assert property (s_rd_a |=> prdata[PA_W-1:0] == $past(pa_read))
        else $error("port a read does not return pin levels");
    a_analog_read_zero: assert property (s_rd_a ##0 (ANALOG_PRESENT && ana_sel_reg == dgp_pkg::ANALOG_RST)
        |=> (prdata[PA_W-1:0] & dgp_pkg::dgp_ana_mask(dgp_pkg::ANALOG_RST)) == '0)
        else $error("analog pin read not zero");
    a_rmw_pin_store: assert property (s_wr_a_rmw |=> latch_a_reg == $past(pa_read))
        else $error("rmw write did not store pin values");
    a_od_never_high: assert property (##1 !pa_out[dgp_pkg::PA_OD_BIT]
        && (pa_oe[dgp_pkg::PA_OD_BIT] -> !$past(latch_a_reg[dgp_pkg::PA_OD_BIT])))
        else $error("open drain pin driven high");
    a_dir_a_hiz: assert property (##1 (pa_oe & $past(dir_a_reg)) == '0)
        else $error("port a input pin driven");
    a_dir_b_drive: assert property (##1 pb_oe == ~$past(dir_b_reg))
        else $error("port b output pin not driven");
    a_pullup_out_off: assert property ((pb_pullup_en & pb_oe) == 8'h00)
        else $error("pull-up on while pin drives");
    a_pullup_opt_off: assert property (opt_reg[dgp_pkg::OPT_PULLUP_N_BIT] |=> pb_pullup_en == 8'h00)
        else $error("pull-up on with enable bit high");
    a_change_sets: assert property (mismatch |=> chg_flag_reg ##1 port_change_flag)
        else $error("mismatch did not set change flag");
    a_set_beats_clear: assert property (mismatch && wr_en && hit_int && !pwdata[dgp_pkg::INT_CHG_FLAG_BIT] |=> chg_flag_reg)
        else $error("clear won over a pending mismatch");
    a_wake_follows: assert property (chg_flag_reg && chg_en_reg |=> wake_req)
        else $error("port change did not request wake");
    a_ext_edge_flag: assert property (ext_edge |=> ext_flag_reg)
        else $error("external edge lost");
    a_ack_one_cycle: assert property ((state_reg == dgp_pkg::DGP_IDLE) && psel && penable |=> pready ##1 !pready)
        else $error("pready not a single cycle");
endmodule // dgp_top
`default_nettype wire

// ### dv/dgp_pin_model.sv
// external pin partner: resolves each port pin from every driver on it
`timescale 1ns/1ps
`default_nettype none
module dgp_pin_model (
    input wire logic pclk,
    input wire logic [dgp_pkg::PA_W-1:0] pa_out,
    input wire logic [dgp_pkg::PA_W-1:0] pa_oe,
    input wire logic [dgp_pkg::PA_W-1:0] pa_ext,
    input wire logic [dgp_pkg::PA_W-1:0] pa_ext_en,
    input wire logic [dgp_pkg::PB_W-1:0] pb_out,
    input wire logic [dgp_pkg::PB_W-1:0] pb_oe,
    input wire logic [dgp_pkg::PB_W-1:0] pb_pullup_en,
    input wire logic [dgp_pkg::PB_W-1:0] pb_ext,
    input wire logic [dgp_pkg::PB_W-1:0] pb_ext_en,
    output logic [dgp_pkg::PA_W-1:0] pa_in,
    output logic [dgp_pkg::PB_W-1:0] pb_in
);
    // **********************
    // pin resolution
    // **********************
    logic [7:0] flt = 8'h55;
    // undriven pins wander every cycle so a stale level never reads as good
    always @(posedge pclk) flt <= ~flt;
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext_en & pa_ext) | (~pa_oe & ~pa_ext_en & flt[5:0]);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext_en & pb_ext) | (~pb_oe & ~pb_ext_en & (pb_pullup_en | flt));
endmodule // dgp_pin_model
`default_nettype wire

// ### dv/dgp_top_test.sv
// self-checking bench for the dual gpio port block
`timescale 1ns/1ps
`default_nettype none
module dgp_top_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, tclk, ss_n, pgc, pgd, chg, ext, wake;
    logic [5:0] pa_in, pa_out, pa_oe, analog_en;
    logic [5:0] pa_ext = 6'h3f;
    logic [5:0] pa_ext_en = 6'h3f;
    logic [7:0] pb_in, pb_out, pb_oe, pb_pu;
    logic [7:0] pb_ext = 8'h00;
    logic [7:0] pb_ext_en = 8'hff;
    logic [5:0] amask [8] = '{6'h2f, 6'h0f, 6'h07, 6'h03, 6'h01, 6'h00, 6'h00, 6'h00};
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;

    always #50 pclk = ~pclk;

    dgp_top u_dgp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .analog_en(analog_en), .pb_in(pb_in), .pb_out(pb_out),
        .pb_oe(pb_oe), .pb_pullup_en(pb_pu), .timer_ext_clock_in(tclk), .ssp_slave_select_n(ss_n),
        .prog_clock(pgc), .prog_data(pgd), .port_change_flag(chg), .ext_irq_flag(ext), .wake_req(wake));

    dgp_pin_model u_dgp_pin_model (.pclk(pclk), .pa_out(pa_out), .pa_oe(pa_oe), .pa_ext(pa_ext),
        .pa_ext_en(pa_ext_en), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup_en(pb_pu), .pb_ext(pb_ext),
        .pb_ext_en(pb_ext_en), .pa_in(pa_in), .pb_in(pb_in));

    // **********************
    // tasks
    // **********************
    task automatic wrap_up();
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] st);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        // the edge that samples pready high completes the transfer; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 4'h1);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 8'h00, 4'h0);
        chk(rd, e);
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    // **********************
    // scenarios
    // **********************
    initial begin
        w(7);
        chk(ss_n, 1'b1);
        @(posedge pclk) presetn <= 1'b1;
        w(3);
        chk(analog_en, 6'h2f);
        chk(pb_pu, 8'h00);
        rdc(dgp_pkg::IDX_OPTION, 8'hff);
        rdc(dgp_pkg::IDX_DIR_A, 6'h3f);
        rdc(dgp_pkg::IDX_DIR_B, 8'hff);
        rdc(dgp_pkg::IDX_ANALOG, 3'h0);
        rdc(dgp_pkg::IDX_PORT_A, 6'h10);
        for (int s = 0; s < 8; s++) begin
            wr(dgp_pkg::IDX_ANALOG, 8'(s));
            w(2);
            chk(analog_en, amask[s]);
        end
        rdc(dgp_pkg::IDX_PORT_A, 6'h3f);
        @(posedge pclk) pa_ext <= 6'h1f;
        w(5);
        chk(ss_n, 1'b0);
        chk(tclk, 1'b1);
        @(posedge pclk) pa_ext <= 6'h15;
        w(5);
        apb(1'b1, dgp_pkg::IDX_PORT_A, 8'hff, 4'h0);
        @(posedge pclk) pa_ext_en <= 6'h00;
        wr(dgp_pkg::IDX_DIR_A, 8'h00);
        w(2);
        chk(pa_oe, 6'h2f);
        chk(pa_out, 6'h05);
        wr(dgp_pkg::IDX_PORT_A, 8'h2a);
        w(4);
        chk(pa_oe, 6'h3f);
        chk(pa_out, 6'h2a);
        chk(tclk, 1'b0);
        rdc(dgp_pkg::IDX_PORT_A, 6'h2a);
        @(posedge pclk) pb_ext_en <= 8'h00;
        wr(dgp_pkg::IDX_OPTION, 8'h7f);
        w(4);
        chk(pb_pu, 8'hff);
        rdc(dgp_pkg::IDX_PORT_B, 8'hff);
        wr(dgp_pkg::IDX_DIR_B, 8'h0f);
        wr(dgp_pkg::IDX_PORT_B, 8'hc0);
        w(5);
        chk(pb_pu, 8'h0f);
        chk(pb_oe, 8'hf0);
        chk({pgd, pgc}, 2'h3);
        @(posedge pclk) pb_ext_en <= 8'hff;
        wr(dgp_pkg::IDX_DIR_B, 8'hff);
        w(4);
        rdc(dgp_pkg::IDX_PORT_B, 8'h00);
        wr(dgp_pkg::IDX_INT_CTRL, 8'h00);
        w(6);
        chk(chg, 1'b0);
        // pin 7 flips only because it turns output; pin 1 is outside the watched nibble
        wr(dgp_pkg::IDX_DIR_B, 8'h7f);
        @(posedge pclk) pb_ext <= 8'h02;
        w(8);
        chk(chg, 1'b0);
        @(posedge pclk) pb_ext <= 8'h22;
        w(8);
        chk({wake, chg}, 2'h1);
        wr(dgp_pkg::IDX_INT_CTRL, 8'h00);
        w(2);
        chk(chg, 1'b1);
        rdc(dgp_pkg::IDX_PORT_B, 8'ha2);
        wr(dgp_pkg::IDX_INT_CTRL, 8'h08);
        w(6);
        chk(chg, 1'b0);
        @(posedge pclk) pb_ext <= 8'h02;
        w(8);
        chk({wake, chg}, 2'h3);
        for (int e = 0; e < 2; e++) begin
            wr(dgp_pkg::IDX_OPTION, e ? 8'hff : 8'hbf);
            @(posedge pclk) pb_ext[0] <= ~e[0];
            w(6);
            wr(dgp_pkg::IDX_INT_CTRL, 8'h00);
            w(4);
            chk(ext, 1'b0);
            @(posedge pclk) pb_ext[0] <= e[0];
            w(6);
            chk(ext, 1'b1);
        end
        apb(1'b0, 8'h40, 8'h00, 4'h0);
        chk(er, 1'b1);
        chk(rd, 32'h00000000);
        wrap_up();
    end
endmodule // dgp_top_test
`default_nettype wire
